//--- hw/ttcr_pkg.sv
// Shared constants for the trace trigger and control register bank.
// Assumes a single 10 MHz system clock and a plain register port.

package ttcr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TRACE = 8'h04;

  // Port trigger control and status fields.
  localparam int TRIG_MODE_BIT = 0;
  localparam int TRIG_OCC_BIT = 1;
  localparam int TRIG_CLR_BIT = 2;
  localparam int MON_ID_BIT = 3;
  localparam int DIR_ID_BIT = 4;

  // Trace control and status fields.
  localparam int EN_BIT = 0;
  localparam int TS_EN_BIT = 1;
  localparam int SYNC_EN_BIT = 2;
  localparam int HW_EN_BIT = 3;
  localparam int TS_CLK_BIT = 4;
  localparam int COMP_BIT = 5;
  localparam int PRESC_LSB = 8;
  localparam int PRESC_MSB = 9;
  localparam int SRC_LSB = 16;
  localparam int SRC_MSB = 22;
  localparam int BUSY_BIT = 23;

  // ****************************************************************
  // Trace bus values
  // ****************************************************************
  localparam int ID_W = 7;
  localparam logic [ID_W-1:0] TRIG_ATB_ID = 7'h70;
  localparam logic [ID_W-1:0] SRC_ID_RST = 7'h00;
  localparam logic [31:0] SYNC_WORD = 32'hFFFF_FFFF;
  localparam logic [1:0] SIZE_B1 = 2'h0;
  localparam logic [1:0] SIZE_B2 = 2'h1;
  localparam logic [1:0] SIZE_B4 = 2'h2;

  typedef enum logic [1:0] {KIND_STIM, KIND_HW, KIND_SYNC} ttcr_kind_e;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PRESC_W = 2;
  localparam int PRESC_STEP = 2;
  localparam int PRESC_CNT_W = 6;
  localparam int SYNC_PERIOD_DEF = 1024;
  localparam int TS_W_DEF = 48;

endpackage

//--- hw/ttcr_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_sys.

`timescale 1ns/100ps

module ttcr_sync3 (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);

  logic s1;
  logic s2;
  logic s3;

  // A change is passed on only once the last two stages agree.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule

//--- hw/ttcr_prescale.sv
// Timestamp prescaler: passes one tick in 1, 4, 16 or 64.
// Assumes tick_in is a one-cycle enable on clk_sys.

`timescale 1ns/100ps

module ttcr_prescale #(
  parameter int CNT_W = ttcr_pkg::PRESC_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tick_in,
  input wire logic [ttcr_pkg::PRESC_W-1:0] sel,
  input wire logic clear,
  output logic tick_out
);

  logic [CNT_W-1:0] count;

  function automatic logic [CNT_W-1:0] last_count(
    input logic [ttcr_pkg::PRESC_W-1:0] s
  );
    last_count = CNT_W'((1 << (ttcr_pkg::PRESC_STEP * int'(s))) - 1);
  endfunction

  assign tick_out = tick_in && !clear && (count >= last_count(sel));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clear || tick_out) begin
      count <= '0;
    end else if (tick_in) begin
      count <= count + 1'b1;
    end
  end

  // A divide-by-4 setting never passes two ticks in a row.
  a_presc_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel == 2'h1 && tick_out) |=> !tick_out)
    else $error("prescaler passed ticks too close together");

endmodule

//--- hw/ttcr_regs.sv
// Trace trigger and trace control registers with packet emission.
// Assumes a plain register port and a ready/valid trace bus sink.

`timescale 1ns/100ps

module ttcr_regs #(
  parameter int TS_W = ttcr_pkg::TS_W_DEF,
  parameter int SYNC_PERIOD = ttcr_pkg::SYNC_PERIOD_DEF,
  parameter bit SYNC_REG_PRESENT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ttcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic stim_wr,
  input wire logic [31:0] stim_data,
  input wire logic [1:0] stim_size,
  input wire logic stim_trig_loc,
  input wire logic stim_port_monitored,
  output logic stim_ready,
  input wire logic hw_evt,
  input wire logic [31:0] hw_evt_data,
  output logic hw_evt_ready,
  input wire logic ts_out_clk,
  input wire logic ts_out_idle,
  output logic trace_valid,
  input wire logic trace_ready,
  output logic [ttcr_pkg::ID_W-1:0] trace_id,
  output ttcr_pkg::ttcr_kind_e trace_kind,
  output logic [31:0] trace_data,
  output logic [1:0] trace_size,
  output logic trace_ts_valid,
  output logic [TS_W-1:0] trace_ts
);

  localparam int SC_W = $clog2(SYNC_PERIOD + 1);
  localparam logic [SC_W-1:0] SYNC_LAST = SC_W'(SYNC_PERIOD - 1);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function automatic logic hit(
    input logic [ttcr_pkg::ADDR_W-1:0] a,
    input logic [ttcr_pkg::ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  logic wr_trig;
  logic wr_trace;
  assign wr_trig = reg_wr && hit(reg_addr, ttcr_pkg::OFS_TRIG);
  assign wr_trace = reg_wr && hit(reg_addr, ttcr_pkg::OFS_TRACE);

  // ****************************************************************
  // Trigger control
  // ****************************************************************
  logic trig_single;
  logic dir_id_en;
  logic mon_id_en;
  logic trig_occ;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trig_single <= 1'b0;
      dir_id_en <= 1'b0;
      mon_id_en <= 1'b0;
    end else if (wr_trig) begin
      trig_single <= reg_wdata[ttcr_pkg::TRIG_MODE_BIT];
      dir_id_en <= reg_wdata[ttcr_pkg::DIR_ID_BIT];
      mon_id_en <= reg_wdata[ttcr_pkg::MON_ID_BIT];
    end
  end

  // ****************************************************************
  // Trace control
  // ****************************************************************
  logic gen_en;
  logic ts_en;
  logic sync_bit;
  logic sync_en;
  logic hw_en;
  logic ts_clk_out;
  logic comp_en;
  logic [ttcr_pkg::PRESC_W-1:0] ts_presc;
  logic [ttcr_pkg::ID_W-1:0] src_id;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gen_en <= 1'b0;
      ts_en <= 1'b0;
      sync_bit <= 1'b0;
      hw_en <= 1'b0;
      ts_clk_out <= 1'b0;
      comp_en <= 1'b0;
      ts_presc <= '0;
      src_id <= ttcr_pkg::SRC_ID_RST;
    end else if (wr_trace) begin
      gen_en <= reg_wdata[ttcr_pkg::EN_BIT];
      ts_en <= reg_wdata[ttcr_pkg::TS_EN_BIT];
      sync_bit <= reg_wdata[ttcr_pkg::SYNC_EN_BIT];
      hw_en <= reg_wdata[ttcr_pkg::HW_EN_BIT];
      ts_clk_out <= reg_wdata[ttcr_pkg::TS_CLK_BIT];
      comp_en <= reg_wdata[ttcr_pkg::COMP_BIT];
      ts_presc <= reg_wdata[ttcr_pkg::PRESC_MSB:ttcr_pkg::PRESC_LSB];
      // Software keeps the generator idle while this changes.
      src_id <= reg_wdata[ttcr_pkg::SRC_MSB:ttcr_pkg::SRC_LSB];
    end
  end

  // With a period register fitted, sync cannot be turned off here.
  assign sync_en = SYNC_REG_PRESENT ? 1'b1 : sync_bit;

  // ****************************************************************
  // Packet slot and arbitration
  // ****************************************************************
  logic pend;
  logic slot_free;
  logic stim_take;
  logic hw_take;
  logic sync_take;
  logic sync_due;
  logic trig_hit;
  logic trig_fire;
  logic busy;

  assign trace_valid = pend;
  assign slot_free = !pend || trace_ready;
  assign stim_ready = gen_en && slot_free;
  assign stim_take = stim_wr && stim_ready;
  assign hw_evt_ready = gen_en && hw_en && slot_free && !stim_wr;
  assign hw_take = hw_evt && hw_evt_ready;
  assign sync_take = sync_due && gen_en && slot_free && !stim_wr
    && !(hw_evt && hw_en);
  assign busy = pend || sync_due;

  assign trig_hit = stim_take && ((stim_trig_loc && dir_id_en)
    || (stim_port_monitored && mon_id_en));
  // In single-shot mode only the first trigger is marked.
  assign trig_fire = trig_hit && !(trig_single && trig_occ);

  // Set wins over a clear written in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trig_occ <= 1'b0;
    end else if (trig_single && trig_fire) begin
      trig_occ <= 1'b1;
    end else if (wr_trig && trig_single
      && reg_wdata[ttcr_pkg::TRIG_CLR_BIT]) begin
      trig_occ <= 1'b0;
    end
  end

  function automatic logic [1:0] packed_size(input logic [31:0] d);
    if (d[31:16] != 16'h0000) begin
      packed_size = ttcr_pkg::SIZE_B4;
    end else if (d[15:8] != 8'h00) begin
      packed_size = ttcr_pkg::SIZE_B2;
    end else begin
      packed_size = ttcr_pkg::SIZE_B1;
    end
  endfunction

  // ****************************************************************
  // Timestamp counter
  // ****************************************************************
  logic ext_clk_s;
  logic ext_clk_d;
  logic idle_s;
  logic base_tick;
  logic ts_tick;
  logic ts_hold;
  logic [TS_W-1:0] ts_count;

  ttcr_sync3 u_sync_clk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(ts_out_clk),
    .q(ext_clk_s)
  );

  ttcr_sync3 u_sync_idle (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(ts_out_idle),
    .q(idle_s)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk_d <= 1'b0;
    end else begin
      ext_clk_d <= ext_clk_s;
    end
  end

  // The output clock is sampled, so it must run well below clk_sys.
  assign base_tick = ts_clk_out ? (ext_clk_s && !ext_clk_d) : 1'b1;
  assign ts_hold = !ts_en || (ts_clk_out && idle_s);

  ttcr_prescale u_presc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick_in(base_tick),
    .sel(ts_presc),
    .clear(ts_hold),
    .tick_out(ts_tick)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ts_count <= '0;
    end else if (ts_hold) begin
      ts_count <= '0;
    end else if (ts_tick) begin
      ts_count <= ts_count + 1'b1;
    end
  end

  // ****************************************************************
  // Synchronization timer
  // ****************************************************************
  logic [SC_W-1:0] sync_cnt;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_cnt <= '0;
      sync_due <= 1'b0;
    end else if (!(gen_en && sync_en)) begin
      sync_cnt <= '0;
      sync_due <= 1'b0;
    end else if (sync_cnt == SYNC_LAST) begin
      sync_cnt <= '0;
      sync_due <= 1'b1;
    end else begin
      sync_cnt <= sync_cnt + 1'b1;
      if (sync_take) begin
        sync_due <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Packet register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 1'b0;
      trace_id <= '0;
      trace_kind <= ttcr_pkg::KIND_STIM;
      trace_data <= '0;
      trace_size <= ttcr_pkg::SIZE_B1;
      trace_ts_valid <= 1'b0;
      trace_ts <= '0;
    end else if (stim_take) begin
      pend <= 1'b1;
      trace_id <= trig_fire ? ttcr_pkg::TRIG_ATB_ID : src_id;
      trace_kind <= ttcr_pkg::KIND_STIM;
      trace_data <= stim_data;
      trace_size <= comp_en ? packed_size(stim_data) : stim_size;
      trace_ts_valid <= ts_en;
      trace_ts <= ts_count;
    end else if (hw_take) begin
      pend <= 1'b1;
      trace_id <= src_id;
      trace_kind <= ttcr_pkg::KIND_HW;
      trace_data <= hw_evt_data;
      trace_size <= ttcr_pkg::SIZE_B4;
      trace_ts_valid <= ts_en;
      trace_ts <= ts_count;
    end else if (sync_take) begin
      pend <= 1'b1;
      trace_id <= src_id;
      trace_kind <= ttcr_pkg::KIND_SYNC;
      trace_data <= ttcr_pkg::SYNC_WORD;
      trace_size <= ttcr_pkg::SIZE_B4;
      trace_ts_valid <= 1'b0;
      trace_ts <= '0;
    end else if (trace_ready) begin
      pend <= 1'b0;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (hit(reg_addr, ttcr_pkg::OFS_TRIG)) begin
      next_rdata[ttcr_pkg::TRIG_MODE_BIT] = trig_single;
      next_rdata[ttcr_pkg::TRIG_OCC_BIT] = trig_single && trig_occ;
      next_rdata[ttcr_pkg::MON_ID_BIT] = mon_id_en;
      next_rdata[ttcr_pkg::DIR_ID_BIT] = dir_id_en;
    end else if (hit(reg_addr, ttcr_pkg::OFS_TRACE)) begin
      // Every optional bit is fitted; each reads back as written, except sync, which reads 1 when SYNC_REG_PRESENT is set.
      next_rdata[ttcr_pkg::EN_BIT] = gen_en;
      next_rdata[ttcr_pkg::TS_EN_BIT] = ts_en;
      next_rdata[ttcr_pkg::SYNC_EN_BIT] = sync_en;
      next_rdata[ttcr_pkg::HW_EN_BIT] = hw_en;
      next_rdata[ttcr_pkg::TS_CLK_BIT] = ts_clk_out;
      next_rdata[ttcr_pkg::COMP_BIT] = comp_en;
      next_rdata[ttcr_pkg::PRESC_MSB:ttcr_pkg::PRESC_LSB] = ts_presc;
      next_rdata[ttcr_pkg::SRC_MSB:ttcr_pkg::SRC_LSB] = src_id;
      next_rdata[ttcr_pkg::BUSY_BIT] = busy;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_trig_dir_id: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stim_take && stim_trig_loc && dir_id_en && !trig_single)
    |=> (trace_valid && trace_id == 7'h70))
    else $error("direct trigger write not marked with trigger id");

  a_trig_mon_id: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stim_take && !stim_trig_loc && !(stim_port_monitored && mon_id_en))
    |=> (trace_id == $past(src_id)))
    else $error("unmonitored write used the trigger id");

  a_single_shot: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (trig_single && trig_hit && !wr_trig) |=> trig_occ ##1
    (!(stim_take && trig_single && !trig_hit) || trace_id != 7'h70))
    else $error("single-shot trigger status not set");

  a_clear_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_trig && reg_wdata[ttcr_pkg::TRIG_CLR_BIT]
    && reg_wdata[ttcr_pkg::TRIG_MODE_BIT] && trig_single && !trig_hit)
    |=> !trig_occ)
    else $error("trigger clear did not clear status");

  a_busy_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && reg_addr == ttcr_pkg::OFS_TRACE && pend)
    |=> reg_rdata[ttcr_pkg::BUSY_BIT])
    else $error("busy bit low while a packet is waiting");

  a_hw_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (trace_valid && trace_kind == ttcr_pkg::KIND_HW && !$past(pend))
    |-> $past(hw_en))
    else $error("hardware event packet while disabled");

  a_sync_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!sync_en || !gen_en) |=> !sync_due)
    else $error("sync packet pending while sync disabled");

  a_ts_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!ts_en && stim_take) |=> (!trace_ts_valid && ts_count == '0))
    else $error("timestamp produced while timestamps disabled");

  a_rsv_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd |=> (reg_rdata[31:24] == 8'h00 && reg_rdata[15:10] == 6'h00
    && reg_rdata[7:6] == 2'h0))
    else $error("reserved bits read nonzero");

endmodule

//--- verif/ttcr_sink.sv
// Trace bus sink standing in for the trace funnel on the far side.
// Assumes the source holds its packet until trace_ready is seen high.

`timescale 1ns/100ps

module ttcr_sink (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hold,
  input wire logic slow,
  output logic trace_ready
);
  // ****************************************************************
  // Acceptance
  // ****************************************************************
  // Ready moves only after an edge; slow mode accepts every other cycle.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trace_ready <= 1'b0;
    end else begin
      trace_ready <= !hold && (!slow || !trace_ready);
    end
  end
endmodule

//--- verif/ttcr_regs_tb.sv
// Self-checking bench for the trace trigger and control registers.
// Assumes ttcr_pkg is compiled first and the sink drives trace_ready.

`timescale 1ns/100ps

module ttcr_regs_tb;
  logic clk_sys, rst_b, reg_wr, reg_rd, stim_wr, stim_trig_loc;
  logic stim_port_monitored, stim_ready, hw_evt, hw_evt_ready;
  logic ts_out_clk, ts_out_idle, trace_valid, trace_ready, trace_ts_valid;
  logic hold, slow, p_tsv;
  logic [ttcr_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, stim_data, hw_evt_data, trace_data;
  logic [31:0] p_data, v;
  logic [1:0] stim_size, trace_size, p_size;
  logic [6:0] trace_id, p_id;
  logic [47:0] trace_ts, p_ts, ts0;
  ttcr_pkg::ttcr_kind_e trace_kind, p_kind;
  int n_fail, total_checks, cyc, t_take, t0;

  ttcr_regs #(.SYNC_PERIOD(16)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stim_wr(stim_wr), .stim_data(stim_data),
    .stim_size(stim_size), .stim_trig_loc(stim_trig_loc),
    .stim_port_monitored(stim_port_monitored), .stim_ready(stim_ready),
    .hw_evt(hw_evt), .hw_evt_data(hw_evt_data),
    .hw_evt_ready(hw_evt_ready), .ts_out_clk(ts_out_clk),
    .ts_out_idle(ts_out_idle), .trace_valid(trace_valid),
    .trace_ready(trace_ready), .trace_id(trace_id),
    .trace_kind(trace_kind), .trace_data(trace_data),
    .trace_size(trace_size), .trace_ts_valid(trace_ts_valid),
    .trace_ts(trace_ts)
  );

  ttcr_sink i_sink (
    .clk_sys(clk_sys), .rst_b(rst_b), .hold(hold), .slow(slow),
    .trace_ready(trace_ready)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // The output clock only runs while the line is busy, as a real port would.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ts_out_clk <= cyc[2] && !ts_out_idle;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask

  // Ends on the take edge so the packet can be caught one cycle later.
  task stim(input logic tl, input logic mon, input logic [31:0] d,
            input logic [1:0] sz);
    int n;
    n = 0;
    stim_trig_loc <= tl;
    stim_port_monitored <= mon;
    stim_data <= d;
    stim_size <= sz;
    stim_wr <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (stim_ready !== 1'b1 && n < 100);
    t_take = cyc;
    stim_wr <= 1'b0;
  endtask

  task pkt;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(trace_valid === 1'b1 && trace_ready === 1'b1) && n < 100);
    chk("packet", 48'h1, 48'(n < 100));
    p_id = trace_id;
    p_kind = trace_kind;
    p_data = trace_data;
    p_size = trace_size;
    p_tsv = trace_ts_valid;
    p_ts = trace_ts;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    rd(ttcr_pkg::OFS_TRIG);
    chk("trig rst", 48'h0, 48'(v));
    rd(ttcr_pkg::OFS_TRACE);
    chk("trace rst", 48'h0, 48'(v));
    wr(ttcr_pkg::OFS_TRACE, 32'hFFFF_FFFE);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(ttcr_pkg::OFS_TRACE);
    chk("trace probe", 48'h007F_033E, 48'(v));
    rd(8'h08);
    chk("unmapped", 48'h0, 48'(v));
    // Clear stays 0 here: the mode is still multi-shot at this write.
    wr(ttcr_pkg::OFS_TRIG, 32'hFFFF_FFFB);
    rd(ttcr_pkg::OFS_TRIG);
    chk("trig probe", 48'h19, 48'(v));
  endtask

  task t_stim;
    wr(ttcr_pkg::OFS_TRACE, 32'h0025_0001);
    wr(ttcr_pkg::OFS_TRIG, 32'h0);
    stim(1'b0, 1'b0, 32'h0000_0012, ttcr_pkg::SIZE_B2);
    pkt;
    chk("id", 48'h25, 48'(p_id));
    chk("kind", 48'(ttcr_pkg::KIND_STIM), 48'(p_kind));
    chk("data", 48'h12, 48'(p_data));
    chk("size", 48'(ttcr_pkg::SIZE_B2), 48'(p_size));
    chk("ts off", 48'h0, 48'(p_tsv));
    slow <= 1'b1;
    wr(ttcr_pkg::OFS_TRACE, 32'h0025_0021);
    stim(1'b0, 1'b0, 32'h0000_0012, ttcr_pkg::SIZE_B4);
    pkt;
    chk("comp 1", 48'(ttcr_pkg::SIZE_B1), 48'(p_size));
    stim(1'b0, 1'b0, 32'h0001_0000, ttcr_pkg::SIZE_B4);
    pkt;
    chk("comp 4", 48'(ttcr_pkg::SIZE_B4), 48'(p_size));
    slow <= 1'b0;
  endtask

  // Every enable pairing against local, monitored and combined writes, multi-shot.
  task t_multi;
    logic [4:0] e;
    logic tl, mon;
    for (int m = 0; m < 4; m++) begin
      e = 5'(m << 3);
      wr(ttcr_pkg::OFS_TRIG, 32'(e));
      for (int i = 1; i < 4; i++) begin
        tl = i[0];
        mon = i[1];
        stim(tl, mon, 32'h5, ttcr_pkg::SIZE_B4);
        pkt;
        chk("trig id", ((tl && e[4]) || (mon && e[3])) ? 48'h70 : 48'h25,
            48'(p_id));
      end
    end
    rd(ttcr_pkg::OFS_TRIG);
    chk("multi status", 48'h18, 48'(v));
  endtask

  task t_single;
    wr(ttcr_pkg::OFS_TRIG, 32'h19);
    stim(1'b1, 1'b0, 32'h7, ttcr_pkg::SIZE_B4);
    pkt;
    chk("first hit", 48'h70, 48'(p_id));
    rd(ttcr_pkg::OFS_TRIG);
    chk("occurred", 48'h1B, 48'(v));
    stim(1'b1, 1'b0, 32'h7, ttcr_pkg::SIZE_B4);
    pkt;
    chk("later hit", 48'h25, 48'(p_id));
    wr(ttcr_pkg::OFS_TRIG, 32'h19);
    rd(ttcr_pkg::OFS_TRIG);
    chk("clear 0", 48'h1B, 48'(v));
    wr(ttcr_pkg::OFS_TRIG, 32'h1D);
    rd(ttcr_pkg::OFS_TRIG);
    chk("clear 1", 48'h19, 48'(v));
    stim(1'b0, 1'b1, 32'h7, ttcr_pkg::SIZE_B4);
    pkt;
    chk("rearmed", 48'h70, 48'(p_id));
    wr(ttcr_pkg::OFS_TRIG, 32'h0);
  endtask

  task t_hw;
    int n;
    n = 0;
    hw_evt_data <= 32'hA5;
    hw_evt <= 1'b1;
    repeat (30) begin
      @(posedge clk_sys);
      n += int'(trace_valid === 1'b1 || hw_evt_ready === 1'b1);
    end
    chk("quiet", 48'h0, 48'(n));
    wr(ttcr_pkg::OFS_TRACE, 32'h0025_0009);
    while (hw_evt_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    hw_evt <= 1'b0;
    pkt;
    chk("hw kind", 48'(ttcr_pkg::KIND_HW), 48'(p_kind));
    chk("hw data", 48'hA5, 48'(p_data));
  endtask

  task t_busy;
    int n;
    n = 0;
    hold <= 1'b1;
    stim(1'b0, 1'b0, 32'h9, ttcr_pkg::SIZE_B4);
    wr(ttcr_pkg::OFS_TRACE, 32'h0025_0000);
    rd(ttcr_pkg::OFS_TRACE);
    chk("busy", 48'h1, 48'(v[ttcr_pkg::BUSY_BIT]));
    hold <= 1'b0;
    pkt;
    chk("held data", 48'h9, 48'(p_data));
    do begin
      rd(ttcr_pkg::OFS_TRACE);
      n++;
    end while (v[ttcr_pkg::BUSY_BIT] !== 1'b0 && n < 20);
    chk("idle", 48'h0, 48'(v[ttcr_pkg::BUSY_BIT]));
    wr(ttcr_pkg::OFS_TRACE, 32'h0033_0001);
    stim(1'b0, 1'b0, 32'h9, ttcr_pkg::SIZE_B4);
    pkt;
    chk("new id", 48'h33, 48'(p_id));
  endtask

  // Two takes exactly 64 cycles apart give a whole number of ticks.
  task ts_pair(input logic [31:0] ctl);
    wr(ttcr_pkg::OFS_TRACE, ctl);
    repeat (8) @(posedge clk_sys);
    stim(1'b0, 1'b0, 32'h1, ttcr_pkg::SIZE_B4);
    pkt;
    ts0 = p_ts;
    t0 = t_take;
    while (cyc != t0 + 63) @(posedge clk_sys);
    stim(1'b0, 1'b0, 32'h1, ttcr_pkg::SIZE_B4);
    pkt;
  endtask

  task t_ts;
    for (int p = 0; p < 4; p++) begin
      ts_pair(32'h0033_0003 | (p << 8));
      chk("ts valid", 48'h1, 48'(p_tsv));
      chk("ts step", 48'(64 >> (2 * p)), p_ts - ts0);
    end
    ts_out_idle <= 1'b1;
    ts_pair(32'h0033_0013);
    chk("ts idle", 48'h0, p_ts);
    ts_out_idle <= 1'b0;
    ts_pair(32'h0033_0013);
    chk("ts ext", 48'h1,
        48'((p_ts - ts0) >= 7 && (p_ts - ts0) <= 9));
  endtask

  task t_sync;
    wr(ttcr_pkg::OFS_TRACE, 32'h0033_0005);
    pkt;
    chk("sync kind", 48'(ttcr_pkg::KIND_SYNC), 48'(p_kind));
    chk("sync data", 48'(ttcr_pkg::SYNC_WORD), 48'(p_data));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, stim_wr, stim_trig_loc, stim_port_monitored} = '0;
    {hw_evt, ts_out_clk, ts_out_idle, hold, slow} = '0;
    reg_addr = '0;
    {reg_wdata, stim_data, hw_evt_data} = '0;
    stim_size = '0;
    cyc = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_stim;
    t_multi;
    t_single;
    t_hw;
    t_busy;
    t_ts;
    t_sync;
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish;
  end
endmodule
